// ### mpo_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mpo_map.svh"

// Operation
// - Six outputs, three pairs, independent or complementary
// - Dead time keeps complementary pair outputs from overlapping
// - Edge or center aligned selectable
// - Twelve-bit counter, prescale 1/2/4/8
// - One timer, six compares drive outputs
// - Fault forces OFF levels without clock
// - Fault mode: per-cycle or latched shutdown
// - Period-synchronous converter trigger
// - Pulses below threshold width suppressed
// - Enables and OFF levels from fixed options
// - One option per side sets OFF level
// - OFF level equals option, active inverse
// - Polarity swaps phases, OFF levels kept
// - Polarity clear: high side active first
// - Polarity change at reload, after dead time
// - Power-on: pins float, then OFF levels
// - System reset drives outputs OFF
// - Disabled pair stays floating for input use
// - Buffered settings load at reload when ready
// - Dead time 1..255 undivided clocks
// - Edge wraps to zero; center counts down

module mpo_top (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic POR_I,
    input wire logic HIGH_SIDE_OFF_LEVEL_OPTION_I,
    input wire logic LOW_SIDE_OFF_LEVEL_OPTION_I,
    input wire logic PAIR0_OUTPUT_ENABLE_OPTION_I,
    input wire logic PAIR1_OUTPUT_ENABLE_OPTION_I,
    input wire logic PAIR2_OUTPUT_ENABLE_OPTION_I,
    input wire logic RUN_I,
    input wire logic INDEPENDENT_MODE_I,
    input wire logic CENTER_ALIGNED_I,
    input wire logic [1:0] PRESCALE_SEL_I,
    input wire logic [1:0] RELOAD_FREQ_I,
    input wire mpo_pkg::mpo_count_type RELOAD_VALUE_I,
    input wire mpo_pkg::mpo_duty_type DUTY0H_I,
    input wire mpo_pkg::mpo_duty_type DUTY0L_I,
    input wire mpo_pkg::mpo_duty_type DUTY1H_I,
    input wire mpo_pkg::mpo_duty_type DUTY1L_I,
    input wire mpo_pkg::mpo_duty_type DUTY2H_I,
    input wire mpo_pkg::mpo_duty_type DUTY2L_I,
    input wire logic [2:0] PAIR_RELATIVE_POLARITY_I,
    input wire mpo_pkg::mpo_db_type DEADTIME_I,
    input wire mpo_pkg::mpo_mpf_type MIN_PULSE_I,
    input wire logic READY_I,
    input wire logic ADC_TRIG_EN_I,
    input wire logic FAULT_I,
    input wire logic FAULT_LATCH_MODE_I,
    input wire logic FAULT_CLEAR_I,
    output logic [2:0] PWM_H_O,
    output logic [2:0] PWM_L_O,
    output logic [2:0] PWM_OE_O,
    output logic ADC_TRIG_O,
    output logic RELOAD_O,
    output logic READY_PENDING_O,
    output logic FAULT_LATCHED_O
);

    // Fault pin synchroniser
    logic fault_meta;
    logic fault_s;

    // Live timing settings
    mpo_pkg::mpo_count_type act_top;
    logic [1:0] act_pres;
    logic [2:0] act_pol;
    mpo_pkg::mpo_duty_type act_duty [`MPO_CHANS];
    logic act_indep;
    logic act_center;
    mpo_pkg::mpo_mpf_type act_mpf;

    logic ready_pending;
    logic [`MPO_DIV_W-1:0] per_cnt;
    logic fault_latched;
    logic fault_cycle;

    // Output path state
    logic [`MPO_CHANS-1:0] filt;
    mpo_pkg::mpo_mpf_type age [`MPO_CHANS];
    logic [2:0] h_q;
    logic [2:0] l_q;
    logic [2:0] oe_q;
    logic adc_q;
    logic reload_q;

    wire mpo_pkg::mpo_duty_type in_duty [`MPO_CHANS];
    wire mpo_pkg::mpo_count_type count;
    wire logic tick;
    wire logic period_end;
    wire logic center_pt;
    wire logic reload_slot;
    wire logic reload_evt;
    wire logic load_now;
    wire logic blocked;
    wire logic [`MPO_CHANS-1:0] cmp;
    wire logic [2:0] h_req;
    wire logic [2:0] l_req;
    wire logic [2:0] h_db;
    wire logic [2:0] l_db;
    wire logic [`MPO_CHANS-1:0] raw;
    wire logic [2:0] pair_en;
    wire logic [2:0] off_h;
    wire logic [2:0] off_l;

    // Signed duty above the unsigned count means active
    function automatic logic duty_hit(input mpo_pkg::mpo_duty_type duty,
                                      input mpo_pkg::mpo_count_type cnt);
        duty_hit = (duty > $signed({{(`MPO_DUTY_W-`MPO_COUNT_W){1'b0}}, cnt}));
    endfunction : duty_hit

    assign in_duty[0] = DUTY0H_I;
    assign in_duty[1] = DUTY0L_I;
    assign in_duty[2] = DUTY1H_I;
    assign in_duty[3] = DUTY1L_I;
    assign in_duty[4] = DUTY2H_I;
    assign in_duty[5] = DUTY2L_I;

    assign pair_en = {PAIR2_OUTPUT_ENABLE_OPTION_I,
                      PAIR1_OUTPUT_ENABLE_OPTION_I,
                      PAIR0_OUTPUT_ENABLE_OPTION_I};
    assign off_h = {3{HIGH_SIDE_OFF_LEVEL_OPTION_I}};
    assign off_l = {3{LOW_SIDE_OFF_LEVEL_OPTION_I}};

    always_ff @(posedge REF_CLK_I)
    begin
        fault_meta <= FAULT_I;
        fault_s <= fault_meta;
    end

    mpo_timebase u_timebase (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .run_i(RUN_I),
        .center_i(act_center),
        .pres_i(act_pres),
        .top_i(act_top),
        .count_o(count),
        .tick_o(tick),
        .period_end_o(period_end),
        .center_pt_o(center_pt)
    );

    // reload every 1, 2, 4 or 8 periods
    assign reload_slot = (per_cnt & mpo_pkg::mpo_pow2_mask(RELOAD_FREQ_I))
                         == mpo_pkg::mpo_pow2_mask(RELOAD_FREQ_I);
    assign reload_evt = period_end && reload_slot;
    assign load_now = !RUN_I || (reload_evt && ready_pending);

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || !RUN_I)
            per_cnt <= '0;
        else if (period_end)
            per_cnt <= per_cnt + `MPO_DIV_W'(1);
    end

    // ready flag, set wins over load
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
            ready_pending <= 1'b0;
        else if (READY_I)
            ready_pending <= 1'b1;
        else if (load_now)
            ready_pending <= 1'b0;
    end

    // buffered settings and polarity move together
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            act_top <= `MPO_TOP_RST;
            act_pres <= `MPO_PRES_RST;
            act_pol <= `MPO_POL_RST;
        end
        else if (load_now)
        begin
            act_top <= RELOAD_VALUE_I;
            act_pres <= PRESCALE_SEL_I;
            act_pol <= PAIR_RELATIVE_POLARITY_I;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        for (int k = 0; k < `MPO_CHANS; k++)
        begin
            if (RST_I)
                act_duty[k] <= `MPO_DUTY_RST;
            else if (load_now)
                act_duty[k] <= in_duty[k];
        end
    end

    // mode and filter width change only while stopped
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            act_indep <= 1'b0;
            act_center <= 1'b0;
            act_mpf <= '0;
        end
        else if (!RUN_I)
        begin
            act_indep <= INDEPENDENT_MODE_I;
            act_center <= CENTER_ALIGNED_I;
            act_mpf <= MIN_PULSE_I;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `MPO_CHANS; g++)
        begin : g_cmp
            assign cmp[g] = duty_hit(act_duty[g], count);
        end
    endgenerate

    generate
        for (g = 0; g < `MPO_PAIRS; g++)
        begin : g_pair
            wire logic ph_h;
            wire logic ph_l;
            assign ph_h = cmp[2*g];
            assign ph_l = act_indep ? cmp[2*g+1] : !cmp[2*g];
            assign h_req[g] = act_pol[g] ? ph_l : ph_h;
            assign l_req[g] = act_pol[g] ? ph_h : ph_l;

            // gap also covers a polarity swap
            mpo_deadband u_db (
                .clk_i(REF_CLK_I),
                .rst_i(RST_I || !RUN_I),
                .bypass_i(act_indep),
                .h_req_i(h_req[g]),
                .l_req_i(l_req[g]),
                .db_i(DEADTIME_I),
                .h_o(h_db[g]),
                .l_o(l_db[g])
            );
            assign raw[2*g] = h_db[g];
            assign raw[2*g+1] = l_db[g];
        end
    endgenerate

    // hold each level at least the threshold in PWM ticks
    always_ff @(posedge REF_CLK_I)
    begin
        for (int k = 0; k < `MPO_CHANS; k++)
        begin
            if (RST_I || !RUN_I)
            begin
                filt[k] <= 1'b0;
                age[k] <= '0;
            end
            else if (raw[k] == filt[k] || age[k] >= act_mpf)
            begin
                filt[k] <= raw[k];
                age[k] <= '0;
            end
            else if (tick && age[k] != '1)
                age[k] <= age[k] + `MPO_MPF_W'(1);
        end
    end

    // latched shutdown, set wins over clear
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
            fault_latched <= 1'b0;
        else if (fault_s && FAULT_LATCH_MODE_I)
            fault_latched <= 1'b1;
        else if (FAULT_CLEAR_I)
            fault_latched <= 1'b0;
    end

    // pulse-by-pulse block until a clean period end
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
            fault_cycle <= 1'b0;
        else if (fault_s && !FAULT_LATCH_MODE_I)
            fault_cycle <= 1'b1;
        else if (period_end || !RUN_I)
            fault_cycle <= 1'b0;
    end

    assign blocked = fault_latched || fault_cycle || fault_s || !RUN_I;

    // levels from options, OFF on reset
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || blocked)
        begin
            h_q <= off_h;
            l_q <= off_l;
        end
        else
        begin
            h_q <= off_h ^ {filt[4], filt[2], filt[0]};
            l_q <= off_l ^ {filt[5], filt[3], filt[1]};
        end
    end

    // float at power-on, then enabled pairs drive
    always_ff @(posedge REF_CLK_I)
    begin
        if (POR_I)
            oe_q <= 3'h0;
        else
            oe_q <= pair_en;
    end

    // trigger at period end, and mid-period when centered
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            adc_q <= 1'b0;
            reload_q <= 1'b0;
        end
        else
        begin
            adc_q <= ADC_TRIG_EN_I && (period_end || center_pt);
            reload_q <= reload_evt && ready_pending;
        end
    end

    // raw fault pin overrides without a clock edge
    assign PWM_H_O = FAULT_I ? off_h : h_q;
    assign PWM_L_O = FAULT_I ? off_l : l_q;
    assign PWM_OE_O = oe_q;
    assign ADC_TRIG_O = adc_q;
    assign RELOAD_O = reload_q;
    assign READY_PENDING_O = ready_pending;
    assign FAULT_LATCHED_O = fault_latched;

endmodule : mpo_top

`default_nettype wire

// ### mpo_map.svh
`ifndef MPO_MAP_SVH
`define MPO_MAP_SVH

// Widths
`define MPO_COUNT_W 12
`define MPO_DUTY_W 16
`define MPO_DB_W 8
`define MPO_MPF_W 8
`define MPO_PAIRS 3
`define MPO_CHANS 6
`define MPO_DIV_W 3

// Reset values of the live timing settings
`define MPO_TOP_RST 12'hFFF
`define MPO_PRES_RST 2'h0
`define MPO_RELF_RST 2'h0
`define MPO_POL_RST 3'h0
`define MPO_DUTY_RST 16'h0000

// Dead time floor, in system clocks
`define MPO_DB_MIN 8'h01

`endif

// ### mpo_pkg.sv
`include "mpo_map.svh"

package mpo_pkg;

    typedef logic [`MPO_COUNT_W-1:0] mpo_count_type;
    typedef logic signed [`MPO_DUTY_W-1:0] mpo_duty_type;
    typedef logic [`MPO_DB_W-1:0] mpo_db_type;
    typedef logic [`MPO_MPF_W-1:0] mpo_mpf_type;

    typedef enum logic {
        MPO_UP,
        MPO_DOWN
    } mpo_dir_type;

    // Divide-by-2^sel expressed as a low mask
    function automatic logic [`MPO_DIV_W-1:0] mpo_pow2_mask(input logic [1:0] sel);
        mpo_pow2_mask = `MPO_DIV_W'((4'h1 << sel) - 4'h1);
    endfunction : mpo_pow2_mask

endpackage : mpo_pkg

// ### mpo_timebase.sv
`timescale 1ns/10ps
`default_nettype none
`include "mpo_map.svh"

module mpo_timebase (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic center_i,
    input wire logic [1:0] pres_i,
    input wire mpo_pkg::mpo_count_type top_i,
    output mpo_pkg::mpo_count_type count_o,
    output logic tick_o,
    output logic period_end_o,
    output logic center_pt_o
);

    logic [`MPO_DIV_W-1:0] div;
    mpo_pkg::mpo_count_type count;
    mpo_pkg::mpo_dir_type dir;
    wire logic at_top;
    wire logic at_zero;

    assign tick_o = run_i && (div == mpo_pkg::mpo_pow2_mask(pres_i));
    assign at_top = (count >= top_i);
    assign at_zero = (count == '0);
    assign count_o = count;
    assign period_end_o = tick_o && (center_i ? (dir == mpo_pkg::MPO_DOWN && at_zero) : at_top);
    assign center_pt_o = tick_o && center_i && dir == mpo_pkg::MPO_UP && at_top;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i || tick_o)
            div <= '0;
        else
            div <= div + `MPO_DIV_W'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            count <= '0;
            dir <= mpo_pkg::MPO_UP;
        end
        else if (tick_o && !center_i)
            count <= at_top ? '0 : count + `MPO_COUNT_W'(1);
        else if (tick_o)
        begin
            unique case (dir)
                mpo_pkg::MPO_UP:
                    if (at_top)
                        dir <= mpo_pkg::MPO_DOWN;
                    else
                        count <= count + `MPO_COUNT_W'(1);
                mpo_pkg::MPO_DOWN:
                    if (at_zero)
                        dir <= mpo_pkg::MPO_UP;
                    else
                        count <= count - `MPO_COUNT_W'(1);
            endcase
        end
    end

endmodule : mpo_timebase

`default_nettype wire

// ### mpo_deadband.sv
`timescale 1ns/10ps
`default_nettype none
`include "mpo_map.svh"

module mpo_deadband (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bypass_i,
    input wire logic h_req_i,
    input wire logic l_req_i,
    input wire mpo_pkg::mpo_db_type db_i,
    output logic h_o,
    output logic l_o
);

    logic [1:0] prev_req;
    mpo_pkg::mpo_db_type cnt;
    wire logic req_chg;
    wire mpo_pkg::mpo_db_type db_len;

    assign req_chg = ({h_req_i, l_req_i} != prev_req);
    assign db_len = (db_i < `MPO_DB_MIN) ? `MPO_DB_MIN : db_i;

    // both sides off while gap runs
    always_ff @(posedge clk_i)
    begin
        prev_req <= {h_req_i, l_req_i};
        if (rst_i)
        begin
            cnt <= '0;
            h_o <= 1'b0;
            l_o <= 1'b0;
        end
        else if (bypass_i)
        begin
            cnt <= '0;
            h_o <= h_req_i;
            l_o <= l_req_i;
        end
        else if (req_chg || cnt != '0)
        begin
            cnt <= req_chg ? db_len - `MPO_DB_W'(1) : cnt - `MPO_DB_W'(1);
            h_o <= 1'b0;
            l_o <= 1'b0;
        end
        else
        begin
            h_o <= h_req_i && !l_req_i;
            l_o <= l_req_i && !h_req_i;
        end
    end

endmodule : mpo_deadband

`default_nettype wire

// ### mpo_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mpo_chk (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic POR_I,
    input wire logic HIGH_SIDE_OFF_LEVEL_OPTION_I,
    input wire logic LOW_SIDE_OFF_LEVEL_OPTION_I,
    input wire logic PAIR0_OUTPUT_ENABLE_OPTION_I,
    input wire logic PAIR1_OUTPUT_ENABLE_OPTION_I,
    input wire logic PAIR2_OUTPUT_ENABLE_OPTION_I,
    input wire logic RUN_I,
    input wire logic INDEPENDENT_MODE_I,
    input wire logic READY_I,
    input wire logic ADC_TRIG_EN_I,
    input wire logic FAULT_I,
    input wire logic FAULT_LATCH_MODE_I,
    input wire logic FAULT_CLEAR_I,
    input wire logic [2:0] PWM_H_O,
    input wire logic [2:0] PWM_L_O,
    input wire logic [2:0] PWM_OE_O,
    input wire logic ADC_TRIG_O,
    input wire logic RELOAD_O,
    input wire logic READY_PENDING_O,
    input wire logic FAULT_LATCHED_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic [2:0] hoff = {3{HIGH_SIDE_OFF_LEVEL_OPTION_I}};
    wire logic [2:0] loff = {3{LOW_SIDE_OFF_LEVEL_OPTION_I}};
    wire logic [2:0] en = {PAIR2_OUTPUT_ENABLE_OPTION_I, PAIR1_OUTPUT_ENABLE_OPTION_I,
        PAIR0_OUTPUT_ENABLE_OPTION_I};
    wire logic all_off = (PWM_H_O == hoff) && (PWM_L_O == loff);

    AST_FAULT_OFF: assert property (FAULT_I |-> all_off)
        else $error("outputs not OFF while fault high");
    AST_NO_OVERLAP: assert property ((!INDEPENDENT_MODE_I &&
        $past(INDEPENDENT_MODE_I, 8) == 1'b0) |-> ((PWM_H_O ^ hoff) & (PWM_L_O ^ loff)) == 3'h0)
        else $error("pair sides active together");
    AST_RESET_OFF: assert property (disable iff (1'b0) RST_I |=> all_off)
        else $error("outputs not OFF after reset");
    AST_POR_FLOAT: assert property (disable iff (1'b0) POR_I |=> PWM_OE_O == 3'h0)
        else $error("pins driven during power-on");
    AST_OE_ENABLE: assert property (disable iff (1'b0)
        (!POR_I && $past(POR_I) == 1'b0) |-> PWM_OE_O == en)
        else $error("pin drive differs from pair enables");
    AST_READY_PEND: assert property (RUN_I && READY_I |=> READY_PENDING_O)
        else $error("ready not held pending");
    AST_RELOAD_CAUSE: assert property (RELOAD_O |-> $past(READY_PENDING_O) ##1 !RELOAD_O)
        else $error("reload without pending ready");
    AST_ADC_GATED: assert property (ADC_TRIG_O |-> $past(ADC_TRIG_EN_I) ##1 !ADC_TRIG_O)
        else $error("converter trigger wrong");
    AST_LATCH_SET: assert property ((FAULT_LATCH_MODE_I && FAULT_I) [*4] |=> FAULT_LATCHED_O)
        else $error("fault not latched");
    AST_LATCH_HOLD: assert property (FAULT_LATCHED_O && !FAULT_CLEAR_I |=> FAULT_LATCHED_O)
        else $error("latched fault dropped");

    cover property (RELOAD_O);
    cover property (FAULT_LATCHED_O);
    cover property (ADC_TRIG_O && !INDEPENDENT_MODE_I);
endmodule : mpo_chk
`default_nettype wire

// ### mpo_gate_model.sv
`timescale 1ns/10ps
`default_nettype none
module mpo_gate_model (
    input wire logic clk_i,
    input wire logic [2:0] h_i,
    input wire logic [2:0] l_i,
    input wire logic [2:0] oe_i,
    input wire logic hoff_i,
    input wire logic loff_i,
    output logic [2:0] h_on_o,
    output logic [2:0] l_on_o,
    output logic shoot_o
);
    logic flip = 1'b0;
    // Floating pins read a toggling level
    wire logic [2:0] h_pin = (oe_i & h_i) | (~oe_i & {3{flip}});
    wire logic [2:0] l_pin = (oe_i & l_i) | (~oe_i & {3{flip}});
    always @(posedge clk_i) flip <= ~flip;
    assign h_on_o = h_pin ^ {3{hoff_i}};
    assign l_on_o = l_pin ^ {3{loff_i}};
    assign shoot_o = |(oe_i & h_on_o & l_on_o);
endmodule : mpo_gate_model
`default_nettype wire

// ### mpo_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic hopt = 1'b0;
    logic lopt = 1'b0;
    logic [2:0] en = 3'h7;
    logic run = 1'b0;
    logic indep = 1'b1;
    logic ctr = 1'b0;
    logic [1:0] pres = 2'h0;
    logic [1:0] relf = 2'h0;
    mpo_pkg::mpo_count_type top = 12'h00F;
    mpo_pkg::mpo_duty_type duty [6] = '{default: 16'h0000};
    logic [2:0] pol = 3'h0;
    mpo_pkg::mpo_db_type db = 8'h01;
    mpo_pkg::mpo_mpf_type minp = 8'h00;
    logic rdy = 1'b0;
    logic flt = 1'b0;
    logic fmode = 1'b0;
    logic fclr = 1'b0;
    logic aen = 1'b1;
    wire logic [2:0] ph, pl, oe, hon, lon;
    wire logic adc, rld, pend, flat, shoot;
    integer seed = 32'haae04c39;
    int num_errors = 0;
    int check_count = 0;
    int span, sh, t, p, n;
    int act [6];
    int dv [6];

    mpo_top i_dut (.REF_CLK_I(clk), .RST_I(rst), .POR_I(por),
        .HIGH_SIDE_OFF_LEVEL_OPTION_I(hopt), .LOW_SIDE_OFF_LEVEL_OPTION_I(lopt),
        .PAIR0_OUTPUT_ENABLE_OPTION_I(en[0]), .PAIR1_OUTPUT_ENABLE_OPTION_I(en[1]),
        .PAIR2_OUTPUT_ENABLE_OPTION_I(en[2]), .RUN_I(run), .INDEPENDENT_MODE_I(indep),
        .CENTER_ALIGNED_I(ctr), .PRESCALE_SEL_I(pres), .RELOAD_FREQ_I(relf),
        .RELOAD_VALUE_I(top), .DUTY0H_I(duty[0]), .DUTY0L_I(duty[1]), .DUTY1H_I(duty[2]),
        .DUTY1L_I(duty[3]), .DUTY2H_I(duty[4]), .DUTY2L_I(duty[5]),
        .PAIR_RELATIVE_POLARITY_I(pol), .DEADTIME_I(db), .MIN_PULSE_I(minp), .READY_I(rdy),
        .ADC_TRIG_EN_I(aen), .FAULT_I(flt), .FAULT_LATCH_MODE_I(fmode),
        .FAULT_CLEAR_I(fclr), .PWM_H_O(ph), .PWM_L_O(pl), .PWM_OE_O(oe), .ADC_TRIG_O(adc),
        .RELOAD_O(rld), .READY_PENDING_O(pend), .FAULT_LATCHED_O(flat));
    mpo_gate_model i_gate (.clk_i(clk), .h_i(ph), .l_i(pl), .oe_i(oe), .hoff_i(hopt),
        .loff_i(lopt), .h_on_o(hon), .l_on_o(lon), .shoot_o(shoot));

    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    function automatic int clampd(input int d, input int tp);
        return (d < 0) ? 0 : ((d > tp) ? tp + 1 : d);
    endfunction : clampd

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic go;
        repeat (8) @(posedge clk);
        run <= 1'b1;
    endtask : go

    // Counts active cycles over two trigger intervals
    task automatic measure;
        span = 0;
        sh = 0;
        act = '{default: 0};
        for (int i = 0; i < 3; i++)
        begin
            do
            begin
                cyc(1);
                if (i > 0)
                begin
                    span++;
                    sh += shoot;
                    for (int c = 0; c < 6; c++)
                        act[c] += c[0] ? lon[c/2] : hon[c/2];
                end
            end while (adc !== 1'b1 && span < 3000);
        end
    endtask : measure

    initial
    begin
        #(4 * 60000);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        hopt <= 1'($random(seed));
        lopt <= 1'($random(seed));
        en <= 3'($random(seed)) | 3'h1;
        cyc(2);
        check(oe, 3'h0);
        check({ph, pl}, {{3{hopt}}, {3{lopt}}});
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        cyc(3);
        check(oe, en);
        $display("test power-on done");
        for (int i = 0; i < 10; i++)
        begin
            t = 2 + ($random(seed) & 15);
            p = $random(seed) & 3;
            for (int k = 0; k < 6; k++)
                dv[k] = $random(seed) % (t + 4);
            if (i == 0)
            begin
                dv[0] = 0;
                dv[1] = t + 1;
            end
            @(posedge clk);
            run <= 1'b0;
            ctr <= i[0];
            pres <= 2'(p);
            top <= 12'(t);
            for (int k = 0; k < 6; k++)
                duty[k] <= 16'(dv[k]);
            go();
            measure();
            check(span, (2 * (t + 1)) << p);
            for (int k = 0; k < 6; k++)
                if (en[k/2])
                    check(act[k], (2 * clampd(dv[k], t)) << p);
        end
        $display("test waveform done");
        for (int i = 1; i < 5; i++)
        begin
            p = $random(seed) & 7;
            t = 5 + ($random(seed) & 3);
            @(posedge clk);
            run <= 1'b0;
            indep <= 1'b0;
            ctr <= 1'b0;
            pres <= 2'h0;
            top <= 12'h00F;
            db <= 8'(i);
            pol <= 3'(p);
            for (int k = 0; k < 6; k++)
                duty[k] <= 16'(t);
            go();
            measure();
            check(sh, 0);
            for (int k = 0; k < 6; k++)
                if (en[k/2])
                    check(act[k], 2 * ((k[0] ^ p[k/2]) ? 16 - t - i : t - i));
        end
        $display("test complementary done");
        @(posedge clk);
        run <= 1'b0;
        indep <= 1'b1;
        pol <= 3'h0;
        minp <= 8'h03;
        for (int k = 0; k < 6; k++)
            duty[k] <= 16'h0001;
        go();
        measure();
        for (int k = 0; k < 6; k++)
            if (en[k/2])
                check(act[k], 0);
        $display("test pulse filter done");
        @(posedge clk);
        run <= 1'b0;
        minp <= 8'h00;
        relf <= 2'($random(seed));
        top <= 12'h007;
        go();
        @(posedge clk);
        top <= 12'h00B;
        measure();
        check(span, 16);
        @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk);
        rdy <= 1'b0;
        #1;
        check(pend, 1'b1);
        n = 0;
        while (rld !== 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        check({rld, pend}, 2'h2);
        measure();
        check(span, 24);
        @(posedge clk);
        aen <= 1'b0;
        n = 0;
        repeat (40)
        begin
            cyc(1);
            n += adc;
        end
        check(n, 0);
        @(posedge clk);
        aen <= 1'b1;
        $display("test reload done");
        @(posedge clk);
        flt <= 1'b1;
        #1;
        check({ph, pl}, {{3{hopt}}, {3{lopt}}});
        @(posedge clk);
        flt <= 1'b0;
        fmode <= 1'b1;
        @(posedge clk);
        flt <= 1'b1;
        repeat (5) @(posedge clk);
        flt <= 1'b0;
        cyc(3);
        check(flat, 1'b1);
        measure();
        for (int k = 0; k < 6; k++)
            if (en[k/2])
                check(act[k], 0);
        @(posedge clk);
        fclr <= 1'b1;
        @(posedge clk);
        fclr <= 1'b0;
        cyc(3);
        check(flat, 1'b0);
        $display("test fault done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        check({oe, ph, pl}, {en, {3{hopt}}, {3{lopt}}});
        $display("test system reset done");
        tally_and_finish();
    end
endmodule : testbench

bind mpo_top mpo_chk i_chk (.REF_CLK_I, .RST_I, .POR_I, .HIGH_SIDE_OFF_LEVEL_OPTION_I,
    .LOW_SIDE_OFF_LEVEL_OPTION_I, .PAIR0_OUTPUT_ENABLE_OPTION_I, .PAIR1_OUTPUT_ENABLE_OPTION_I,
    .PAIR2_OUTPUT_ENABLE_OPTION_I, .RUN_I, .INDEPENDENT_MODE_I, .READY_I, .ADC_TRIG_EN_I,
    .FAULT_I, .FAULT_LATCH_MODE_I, .FAULT_CLEAR_I, .PWM_H_O, .PWM_L_O, .PWM_OE_O,
    .ADC_TRIG_O, .RELOAD_O, .READY_PENDING_O, .FAULT_LATCHED_O);
`default_nettype wire
